// *** rtl/pcc_pkg.sv ***
// Constants for the PWM cycle configuration block of the counter array.
// Assumes an 8-bit special-function register bus with one-cycle strobes.
`default_nettype none
package pcc_pkg;
   // ==========================================================
   // Sizes
   localparam int NUM_MOD = 6;                // Capture/compare modules
   localparam int CNT_W   = 16;               // Main array counter width
   // ==========================================================
   // Configuration register
   localparam logic [7:0] CFG_ADDR   = 8'hd9;
   localparam logic [7:0] CFG_RESET  = 8'h00;
   localparam int         RELOAD_BIT = 7;     // Reload window select
   localparam int         IRQEN_BIT  = 6;     // Cycle-wrap interrupt enable
   localparam int         FLAG_BIT   = 5;     // Cycle-wrap flag
   localparam int         LENSEL_LSB = 0;     // Two-bit cycle length select
   localparam logic [2:0] UNUSED_VAL = 3'h0;  // Bits 4:2 always read as zero
   // ==========================================================
   // Compare value addresses: low byte at base + 2n, high byte at base + 2n + 1
   localparam logic [7:0] CMP_BASE   = 8'he0;
   localparam logic [15:0] CMP_RESET = 16'h0000;
   localparam logic [15:0] ARL_RESET = 16'h0000;
   localparam logic [7:0]  RD_IDLE   = 8'h00; // Read answer for unmapped addresses
   // ==========================================================
   // Cycle lengths in bits
   localparam logic [4:0] LEN_BASE = 5'h08;   // Length for select value 00
   localparam logic [4:0] LEN_WIDE = 5'h10;   // Length of 16-bit PWM
endpackage
`default_nettype wire

// *** rtl/pcc_top.sv ***
// PWM cycle configuration register, cycle-wrap flag and compare/reload steering.
// Assumes the counter, its tick enable and the per-module mode bits come from
// logic on the same clock; the interrupt request joins the array's shared line.
//
// Function
// - Compare addresses reach compare registers if reload select is 0, reload if 1.
// - Auto-reload value used only in 9, 10 and 11-bit cycle lengths.
// - Interrupt request when wrap flag set and its enable is 1, else none.
// - Wrap flag set on overflow of the counter bit chosen by length select.
// - Wrap flag set by hardware or software 1; only software clears it.
// - Configuration bits 4 to 2 read as zero, writes to them ignored.
// - Length select 00/01/10/11 gives 8/9/10/11-bit cycles.
// - Selected length applies to every PWM channel not in 16-bit mode.
// - Wide select 0 gives 8 to 11-bit PWM, 1 gives 16-bit PWM.
`timescale 1ns/10ps
`default_nettype none
module pcc_top (
   input  wire logic                                   clock_i,
   input  wire logic                                   rst_b_i,
   input  wire logic [7:0]                             sfr_addr_i,
   input  wire logic [7:0]                             sfr_wdata_i,
   input  wire logic                                   sfr_wr_i,
   input  wire logic                                   sfr_rd_i,
   output logic      [7:0]                             sfr_rdata_o,
   input  wire logic [pcc_pkg::CNT_W-1:0]              counter_i,
   input  wire logic                                   count_tick_i,
   input  wire logic [pcc_pkg::NUM_MOD-1:0]            pwm_enable_i,
   input  wire logic [pcc_pkg::NUM_MOD-1:0]            wide_pwm_select_i,
   output logic                                        cycle_wrap_flag_o,
   output logic                                        irq_req_o,
   output logic      [1:0]                             cycle_length_select_o,
   output logic      [pcc_pkg::NUM_MOD-1:0][4:0]       chan_len_o,
   output logic      [pcc_pkg::NUM_MOD-1:0]            chan_use_reload_o,
   output logic      [pcc_pkg::NUM_MOD-1:0][15:0]      compare_value_o,
   output logic      [pcc_pkg::NUM_MOD-1:0][15:0]      reload_value_o
);
   // ==========================================================
   // State
   typedef struct packed {
      logic                                    reload_sel;
      logic                                    wrap_irq_en;
      logic                                    wrap_flag;
      logic [1:0]                              len_sel;
      logic [pcc_pkg::NUM_MOD-1:0][15:0]       cmp;
      logic [pcc_pkg::NUM_MOD-1:0][15:0]       arl;
      logic [7:0]                              rdata;
   } pcc_state_t;

   pcc_state_t st_r;
   pcc_state_t st_nxt;
   logic       wrap;
   logic       cfg_wr;
   logic       cmp_hit;
   logic       cmp_high;
   logic [2:0] cmp_idx;

   // ==========================================================
   // Address decode of the compare value bytes, shared by read and write
   function automatic logic [4:0] cmp_decode(input logic [7:0] addr);
      logic [7:0] off;
      logic [4:0] res;
      off = addr - pcc_pkg::CMP_BASE;
      res = '0;
      if (addr >= pcc_pkg::CMP_BASE && off < 8'(2 * pcc_pkg::NUM_MOD)) begin
         res = {1'b1, off[0], off[3:1]};
      end
      return res;
   endfunction

   // Low N counter bits all ones on a tick means they wrap to zero next
   function automatic logic wrap_at(input logic [1:0] sel, input logic [15:0] cnt);
      logic w;
      w = 1'b0;
      unique case (sel)
         2'b00: w = &cnt[7:0];
         2'b01: w = &cnt[8:0];
         2'b10: w = &cnt[9:0];
         2'b11: w = &cnt[10:0];
      endcase
      return w;
   endfunction

   assign {cmp_hit, cmp_high, cmp_idx} = cmp_decode(sfr_addr_i);
   assign cfg_wr = sfr_wr_i && (sfr_addr_i == pcc_pkg::CFG_ADDR);
   assign wrap   = count_tick_i && wrap_at(st_r.len_sel, counter_i);

   // ==========================================================
   // Next state: register writes, flag set, registered read answer
   always_comb begin
      st_nxt = st_r;
      if (cfg_wr) begin
         // Bits 4:2 are not stored, so a write there has no effect
         st_nxt.reload_sel  = sfr_wdata_i[pcc_pkg::RELOAD_BIT];
         st_nxt.wrap_irq_en = sfr_wdata_i[pcc_pkg::IRQEN_BIT];
         st_nxt.wrap_flag   = sfr_wdata_i[pcc_pkg::FLAG_BIT];
         st_nxt.len_sel     = sfr_wdata_i[pcc_pkg::LENSEL_LSB +: 2];
      end
      // Hardware set is applied last so it beats a same-cycle software clear
      if (wrap) begin
         st_nxt.wrap_flag = 1'b1;
      end
      if (sfr_wr_i && cmp_hit) begin
         // Same address, two storage banks chosen by the reload select
         if (st_r.reload_sel) begin
            if (cmp_high) st_nxt.arl[cmp_idx][15:8] = sfr_wdata_i;
            else          st_nxt.arl[cmp_idx][7:0]  = sfr_wdata_i;
         end else begin
            if (cmp_high) st_nxt.cmp[cmp_idx][15:8] = sfr_wdata_i;
            else          st_nxt.cmp[cmp_idx][7:0]  = sfr_wdata_i;
         end
      end
      if (sfr_rd_i) begin
         if (sfr_addr_i == pcc_pkg::CFG_ADDR) begin
            st_nxt.rdata = {st_r.reload_sel, st_r.wrap_irq_en, st_r.wrap_flag,
                            pcc_pkg::UNUSED_VAL, st_r.len_sel};
         end else if (cmp_hit) begin
            st_nxt.rdata = st_r.reload_sel ?
                           (cmp_high ? st_r.arl[cmp_idx][15:8] : st_r.arl[cmp_idx][7:0]) :
                           (cmp_high ? st_r.cmp[cmp_idx][15:8] : st_r.cmp[cmp_idx][7:0]);
         end else begin
            st_nxt.rdata = pcc_pkg::RD_IDLE;
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r       <= '0;
         st_r.reload_sel  <= pcc_pkg::CFG_RESET[pcc_pkg::RELOAD_BIT];
         st_r.wrap_irq_en <= pcc_pkg::CFG_RESET[pcc_pkg::IRQEN_BIT];
         st_r.wrap_flag   <= pcc_pkg::CFG_RESET[pcc_pkg::FLAG_BIT];
         st_r.len_sel     <= pcc_pkg::CFG_RESET[pcc_pkg::LENSEL_LSB +: 2];
         st_r.cmp   <= {pcc_pkg::NUM_MOD{pcc_pkg::CMP_RESET}};
         st_r.arl   <= {pcc_pkg::NUM_MOD{pcc_pkg::ARL_RESET}};
         st_r.rdata <= pcc_pkg::RD_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // Flag is masked by its enable before joining the shared request
   assign irq_req_o             = st_r.wrap_flag && st_r.wrap_irq_en;
   assign cycle_wrap_flag_o     = st_r.wrap_flag;
   assign cycle_length_select_o = st_r.len_sel;
   assign sfr_rdata_o           = st_r.rdata;
   assign compare_value_o       = st_r.cmp;
   assign reload_value_o        = st_r.arl;

   // Per-channel length and reload use; reload only matters in 9 to 11 bits
   for (genvar ch = 0; ch < pcc_pkg::NUM_MOD; ch++) begin : g_chan
      assign chan_len_o[ch] = wide_pwm_select_i[ch] ? pcc_pkg::LEN_WIDE :
                              pcc_pkg::LEN_BASE + {3'h0, st_r.len_sel};
      assign chan_use_reload_o[ch] = pwm_enable_i[ch] && !wide_pwm_select_i[ch]
                                     && (st_r.len_sel != 2'b00);

      wide_len_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
         wide_pwm_select_i[ch] |-> chan_len_o[ch] == 5'h10)
         else $error("wide channel not at 16-bit length");
      narrow_len_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
         !wide_pwm_select_i[ch] |-> chan_len_o[ch] == 5'(8 + st_r.len_sel))
         else $error("narrow channel ignores length select");
      reload_use_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
         chan_use_reload_o[ch] |-> (pwm_enable_i[ch] && !wide_pwm_select_i[ch]
                                    && st_r.len_sel != 2'b00))
         else $error("reload used outside 9 to 11-bit cycles");
   end

   // ==========================================================
   // Checks
   wrap_set_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (count_tick_i && st_r.len_sel == 2'b01 && counter_i[8:0] == 9'h1ff)
      |=> cycle_wrap_flag_o)
      else $error("9-bit wrap did not set flag");
   no_false_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (!cycle_wrap_flag_o && !cfg_wr && !(count_tick_i && counter_i[7:0] == 8'hff))
      |=> !cycle_wrap_flag_o)
      else $error("flag set without a wrap");
   flag_hold_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (cycle_wrap_flag_o && !cfg_wr) |=> cycle_wrap_flag_o)
      else $error("flag cleared by hardware");
   set_beats_clr_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (cfg_wr && !sfr_wdata_i[5] && wrap) |=> cycle_wrap_flag_o)
      else $error("wrap lost to software clear");
   irq_mask_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (cfg_wr && !sfr_wdata_i[6]) |=> !irq_req_o)
      else $error("masked flag raised request");
   reserved_rd_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (sfr_rd_i && sfr_addr_i == 8'hd9) |=> sfr_rdata_o[4:2] == 3'h0)
      else $error("unused bits read non-zero");
   reload_steer_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (sfr_wr_i && cmp_hit && !cmp_high && st_r.reload_sel)
      |=> (reload_value_o[$past(cmp_idx)][7:0] == $past(sfr_wdata_i))
          && $stable(compare_value_o))
      else $error("reload bank write misrouted");
   cmp_steer_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (sfr_wr_i && cmp_hit && cmp_high && !st_r.reload_sel)
      |=> (compare_value_o[$past(cmp_idx)][15:8] == $past(sfr_wdata_i))
          && $stable(reload_value_o))
      else $error("compare bank write misrouted");
   wrap_set8_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (count_tick_i && st_r.len_sel == 2'b00 && counter_i[7:0] == 8'hff)
      |=> cycle_wrap_flag_o)
      else $error("8-bit wrap did not set flag");
   wrap_set11_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (count_tick_i && st_r.len_sel == 2'b11 && counter_i[10:0] == 11'h7ff)
      |=> cycle_wrap_flag_o)
      else $error("11-bit wrap did not set flag");
   // A wrap of the low byte alone must not count while 9 bits are selected
   wrap_bit_sel_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (!cycle_wrap_flag_o && !cfg_wr && st_r.len_sel == 2'b01 && !counter_i[8])
      |=> !cycle_wrap_flag_o)
      else $error("flag set below the selected bit");
   irq_raise_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (cfg_wr && sfr_wdata_i[6] && sfr_wdata_i[5]) |=> irq_req_o)
      else $error("enabled flag raised no request");
   reload_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      (sfr_rd_i && cmp_hit && !cmp_high && st_r.reload_sel)
      |=> sfr_rdata_o == $past(reload_value_o[cmp_idx][7:0]))
      else $error("reload bank read misrouted");
endmodule
`default_nettype wire

// *** tb/pwm_cycle_config_tb_top.sv ***
// Self-checking bench for the PWM cycle configuration block.
// Assumes pcc_pkg and pcc_top are compiled first; inputs move on falling edges.
`timescale 1ns/10ps
`default_nettype none
module pwm_cycle_config_tb_top;
   // ==========================================================
   // Signals and reference model state
   logic clock_i, rst_b_i, sfr_wr_i, sfr_rd_i, count_tick_i, cycle_wrap_flag_o, irq_req_o;
   logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, cfg;
   logic [15:0] counter_i;
   logic [1:0]  cycle_length_select_o;
   logic [pcc_pkg::NUM_MOD-1:0]        pwm_enable_i, wide_pwm_select_i, chan_use_reload_o;
   logic [pcc_pkg::NUM_MOD-1:0][4:0]  chan_len_o;
   logic [pcc_pkg::NUM_MOD-1:0][15:0] compare_value_o, reload_value_o;
   logic [7:0]  bank [2][12];                       // Compare bank 0, reload bank 1
   int          err_total, n_tests, seed;
   pcc_top dut (.clock_i, .rst_b_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i,
      .sfr_rdata_o, .counter_i, .count_tick_i, .pwm_enable_i, .wide_pwm_select_i,
      .cycle_wrap_flag_o, .irq_req_o, .cycle_length_select_o, .chan_len_o,
      .chan_use_reload_o, .compare_value_o, .reload_value_o);
   // ==========================================================
   // Compare, bus and counter tasks
   task automatic chk(input logic [191:0] got, input logic [191:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      if (a == pcc_pkg::CFG_ADDR) return cfg;
      if (a >= pcc_pkg::CMP_BASE && a < pcc_pkg::CMP_BASE + 8'h0c)
         return bank[cfg[7]][a - pcc_pkg::CMP_BASE];
      return pcc_pkg::RD_IDLE;
   endfunction
   // Every output but sfr_rdata_o checked at once, so a stray side effect shows anywhere
   task automatic chk_all;
      logic [pcc_pkg::NUM_MOD-1:0][4:0]  len;
      logic [pcc_pkg::NUM_MOD-1:0][15:0] cv, rv;
      logic [5:0] use_r;
      for (int i = 0; i < 6; i++) begin
         len[i] = wide_pwm_select_i[i] ? pcc_pkg::LEN_WIDE : pcc_pkg::LEN_BASE + 5'(cfg[1:0]);
         use_r[i] = pwm_enable_i[i] & ~wide_pwm_select_i[i] & (cfg[1:0] != 2'h0);
         cv[i] = {bank[0][2*i+1], bank[0][2*i]};
         rv[i] = {bank[1][2*i+1], bank[1][2*i]};
      end
      chk(192'({cycle_wrap_flag_o, irq_req_o, cycle_length_select_o, chan_len_o,
         chan_use_reload_o}), 192'({cfg[5], cfg[5] & cfg[6], cfg[1:0], len, use_r}));
      chk({compare_value_o, reload_value_o}, {cv, rv});
   endtask
   // One strobe cycle then one idle cycle, so strobes never change twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      counter_i = 16'($random(seed));                // Counter moves while tick is low
      @(negedge clock_i);
      sfr_wr_i = 1'b0;
      if (a == pcc_pkg::CFG_ADDR) cfg = d & 8'he3;
      else if (a >= pcc_pkg::CMP_BASE && a < pcc_pkg::CMP_BASE + 8'h0c)
         bank[cfg[7]][a - pcc_pkg::CMP_BASE] = d;
      @(negedge clock_i);
   endtask
   task automatic rd(input logic [7:0] a);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      @(negedge clock_i);
      sfr_rd_i = 1'b0;
      chk(192'(sfr_rdata_o), 192'(exp_rd(a)));
      @(negedge clock_i);
   endtask
   // Counter tick, optionally with a flag-clearing write in the same cycle
   task automatic tick(input logic [15:0] c, input logic clr);
      logic [15:0] m;
      m = (16'h0100 << cfg[1:0]) - 16'h0001;          // Low N bits of the cycle
      counter_i = c;
      count_tick_i = 1'b1;
      sfr_addr_i = pcc_pkg::CFG_ADDR;
      sfr_wdata_i = cfg & 8'hdf;
      sfr_wr_i = clr;
      @(negedge clock_i);
      count_tick_i = 1'b0;
      sfr_wr_i = 1'b0;
      if (clr) cfg[5] = 1'b0;
      if ((c & m) == m) cfg[5] = 1'b1;                // Hardware set wins over the clear
      chk_all;
      @(negedge clock_i);
   endtask
   task automatic close_out;
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ==========================================================
   // Clock and hang guard
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial begin
      #100000;
      err_total++;
      close_out;
   end
   // ==========================================================
   // Main sequence
   initial begin
      {rst_b_i, sfr_wr_i, sfr_rd_i, count_tick_i, sfr_addr_i, sfr_wdata_i} = '0;
      {counter_i, pwm_enable_i, wide_pwm_select_i, cfg, err_total, n_tests} = '0;
      seed = 32'h40a7;
      for (int i = 0; i < 12; i++) bank[0][i] = 8'h00;
      for (int i = 0; i < 12; i++) bank[1][i] = 8'h00;
      repeat (4) @(negedge clock_i);
      rst_b_i = 1'b1;
      rd(pcc_pkg::CFG_ADDR);
      chk_all;
      // Each length select with random modes, reserved bits and flag writes
      for (int s = 0; s < 4; s++) begin
         pwm_enable_i = 6'($random(seed));
         wide_pwm_select_i = 6'($random(seed));
         wr(pcc_pkg::CFG_ADDR, (8'($random(seed)) & 8'hfc) | 8'(s));
         rd(pcc_pkg::CFG_ADDR);
         chk_all;
         wr(pcc_pkg::CFG_ADDR, (cfg & 8'h9f) | 8'(s % 2 * 64));
         chk_all;
         tick((16'($random(seed)) | ((16'h0100 << s) - 16'h1)) & ~(16'h0080 << s), 1'b0);
         tick(16'($random(seed)) | ((16'h0100 << s) - 16'h1), 1'b0);
         tick(16'h0000, 1'b0);
         tick(16'($random(seed)) | ((16'h0100 << s) - 16'h1), 1'b1);
         tick(16'h0000, 1'b1);
      end
      // Both banks through the same addresses, plus an unmapped write
      for (int b = 0; b < 2; b++) begin
         wr(pcc_pkg::CFG_ADDR, 8'(b * 128));
         for (int a = 8'he0; a < 8'hec; a++) wr(8'(a), 8'($random(seed)));
         wr(8'hf0, 8'($random(seed)));
         for (int a = 8'he0; a < 8'hef; a++) rd(8'(a));
         chk_all;
      end
      close_out;
   end
endmodule
`default_nettype wire
